// file: core/lsm_regs.vh
// register map and field layout of the line status monitor
// assumes a word-wide AHB-Lite slave; byte address = 4 x register index
`ifndef LSM_REGS_VH
`define LSM_REGS_VH

// ----------------------------------------------------------------
// address layout
// ----------------------------------------------------------------
`define LSM_IDX_LSB        2
`define LSM_IDX_MSB        9
`define LSM_CHAN_LSB       6
`define LSM_CHAN_MSB       7
`define LSM_OFF_MSB        5

// ----------------------------------------------------------------
// register indices within one channel (channel stride 40H)
// ----------------------------------------------------------------
`define LSM_IDX_PRIMARY    6'h14
`define LSM_IDX_SECONDARY  6'h15
`define LSM_IDX_INT_STATUS 6'h16
`define LSM_IDX_MASK       6'h20
`define LSM_IDX_EDGE_SEL   6'h21

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LSM_BIT_DRIVER     2
`define LSM_BIT_ALARM      1
`define LSM_BIT_LOSS       0
`define LSM_BIT_LOOPBACK   5
`define LSM_ATT_MSB        4
`define LSM_ATT_LSB        0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LSM_FLAGS_RESET    3'h0
`define LSM_MASK_RESET     3'h7
`define LSM_EDGE_RESET     3'h0
`define LSM_INT_RESET      3'h0
`define LSM_ATT_RESET      5'h00
`define LSM_WORD_ZERO      32'h0000_0000

// ----------------------------------------------------------------
// attenuation coding: 2 dB steps, saturating above 44 dB
// ----------------------------------------------------------------
`define LSM_ATT_TOP_DB     44
`define LSM_ATT_OVER_CODE  5'h16

`endif

// file: core/lsm_event_gen.v
// status-change event generator for one channel's three line flags
// assumes flag_old is the registered flag and flag_new the value it takes next
`timescale 1ns/1ps
`default_nettype none

module lsm_event_gen #(
  parameter WIDTH = 3
) (
  input  wire [WIDTH-1:0] flag_new_in,
  input  wire [WIDTH-1:0] flag_old_in,
  input  wire [WIDTH-1:0] mask_in,
  input  wire [WIDTH-1:0] edge_sel_in,
  output wire [WIDTH-1:0] event_out
);

  // ----------------------------------------------------------------
  // edge classification
  // ----------------------------------------------------------------
  wire [WIDTH-1:0] rise;
  wire [WIDTH-1:0] change;

  assign rise   = flag_new_in & ~flag_old_in;
  assign change = flag_new_in ^ flag_old_in;

  // ----------------------------------------------------------------
  // event select
  // ----------------------------------------------------------------
  // bit 2 driver fault, bit 1 alarm indication, bit 0 signal loss
  // mask 0 enables; edge-select 0 rising only, 1 any change
  wire [WIDTH-1:0] armed;

  assign armed     = (edge_sel_in & change) | (~edge_sel_in & rise);
  assign event_out = ~mask_in & armed;

endmodule

`default_nettype wire

// file: core/lsm_line_status_monitor.v
// per-channel real-time line status registers with status-change events
// assumes AHB-Lite single word transfers and inputs synchronous to core_clk_in
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "lsm_regs.vh"

module lsm_line_status_monitor #(
  parameter CHANNELS = 4,
  parameter ATT_W    = 6
) (
  input  wire                      core_clk_in,
  input  wire                      reset_in,
  input  wire                      hsel_in,
  input  wire [31:0]               haddr_in,
  input  wire [1:0]                htrans_in,
  input  wire                      hwrite_in,
  input  wire [2:0]                hsize_in,
  input  wire                      hready_in,
  input  wire [31:0]               hwdata_in,
  output reg  [31:0]               hrdata_out,
  output reg                       hreadyout_out,
  output reg                       hresp_out,
  input  wire [CHANNELS-1:0]       driver_short_in,
  input  wire [CHANNELS-1:0]       alarm_indication_in,
  input  wire [CHANNELS-1:0]       signal_loss_in,
  input  wire [CHANNELS-1:0]       remote_loopback_in,
  input  wire [CHANNELS*ATT_W-1:0] line_attenuation_db_in
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // whole-dB measurement to 5-bit code; odd dB falls in the lower step
  function [4:0] lsm_att_code;
    input [ATT_W-1:0] db;
    reg   [ATT_W-1:0] half;
    begin
      half = db >> 1;
      if (db >= `LSM_ATT_TOP_DB) begin
        lsm_att_code = `LSM_ATT_OVER_CODE;
      end else begin
        lsm_att_code = half[4:0];
      end
    end
  endfunction

  // register offset match within a channel's window
  function lsm_hit;
    input [7:0] idx;
    input [5:0] off;
    begin
      lsm_hit = (idx[`LSM_OFF_MSB:0] == off);
    end
  endfunction

  // mapped only when the channel exists and upper address bits are zero
  // the channel field is two address bits, so at most four channels are reachable
  function lsm_mapped;
    input [31:0] addr;
    begin
      lsm_mapped = (addr[31:`LSM_IDX_MSB+1] == 22'h00_0000) &&
                   (addr[`LSM_CHAN_MSB+`LSM_IDX_LSB:`LSM_CHAN_LSB+`LSM_IDX_LSB] < CHANNELS);
    end
  endfunction

  // three-bit field in the low bits of an otherwise zero word
  function [31:0] lsm_flag_word;
    input [2:0] bits;
    begin
      lsm_flag_word = {29'h000_0000, bits};
    end
  endfunction

  // ----------------------------------------------------------------
  // per-channel state
  // ----------------------------------------------------------------
  reg  [2:0]             line_flags    [0:CHANNELS-1];
  reg                    loopback      [0:CHANNELS-1];
  reg  [4:0]             att_code      [0:CHANNELS-1];
  reg  [2:0]             int_status    [0:CHANNELS-1];
  reg  [2:0]             mask          [0:CHANNELS-1];
  reg  [2:0]             edge_sel      [0:CHANNELS-1];
  wire [3*CHANNELS-1:0]  event_bus;
  wire [3*CHANNELS-1:0]  flag_new_bus;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       accept;
  wire       rd_accept;
  wire       wr_accept;
  wire [7:0] idx;
  wire [1:0] chan;
  wire       mapped;

  assign accept    = hsel_in & htrans_in[1] & hready_in;
  assign rd_accept = accept & ~hwrite_in;
  assign wr_accept = accept & hwrite_in;
  assign idx       = haddr_in[`LSM_IDX_MSB:`LSM_IDX_LSB];
  assign chan      = idx[`LSM_CHAN_MSB:`LSM_CHAN_LSB];
  assign mapped    = lsm_mapped(haddr_in);

  // one select per register; unmapped addresses select nothing
  wire       sel_primary;
  wire       sel_secondary;
  wire       sel_int;
  wire       sel_mask;
  wire       sel_edge;

  assign sel_primary   = mapped & lsm_hit(idx, `LSM_IDX_PRIMARY);
  assign sel_secondary = mapped & lsm_hit(idx, `LSM_IDX_SECONDARY);
  assign sel_int       = mapped & lsm_hit(idx, `LSM_IDX_INT_STATUS);
  assign sel_mask      = mapped & lsm_hit(idx, `LSM_IDX_MASK);
  assign sel_edge      = mapped & lsm_hit(idx, `LSM_IDX_EDGE_SEL);

  // write data phase bookkeeping
  reg        wr_pend;
  reg  [7:0] wr_idx;

  wire [1:0] wr_chan;
  wire       wr_mask;
  wire       wr_edge;

  assign wr_chan = wr_idx[`LSM_CHAN_MSB:`LSM_CHAN_LSB];
  assign wr_mask = wr_pend & lsm_hit(wr_idx, `LSM_IDX_MASK);
  assign wr_edge = wr_pend & lsm_hit(wr_idx, `LSM_IDX_EDGE_SEL);

  // read of the interrupt status register clears it at the same edge
  wire rd_clear;

  assign rd_clear = rd_accept & sel_int;

  // ----------------------------------------------------------------
  // event generation
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : gen_chan
      assign flag_new_bus[3*g+2] = driver_short_in[g];
      assign flag_new_bus[3*g+1] = alarm_indication_in[g];
      assign flag_new_bus[3*g]   = signal_loss_in[g];

      // compares the incoming level with the stored flag so the event
      // latches on the same edge that the flag updates
      lsm_event_gen #(
        .WIDTH (3)
      ) u_event (
        .flag_new_in (flag_new_bus[3*g+2:3*g]),
        .flag_old_in (line_flags[g]),
        .mask_in     (mask[g]),
        .edge_sel_in (edge_sel[g]),
        .event_out   (event_bus[3*g+2:3*g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // status capture
  // ----------------------------------------------------------------
  integer i;
  integer j;
  integer k;

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        line_flags[i] <= `LSM_FLAGS_RESET;
        loopback[i]   <= 1'b0;
        att_code[i]   <= `LSM_ATT_RESET;
      end
    end else begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        // status follows the detectors every cycle, no hold or latch
        line_flags[i] <= flag_new_bus[3*i+:3];
        loopback[i]   <= remote_loopback_in[i];
        att_code[i]   <= lsm_att_code(line_attenuation_db_in[ATT_W*i+:ATT_W]);
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status latch
  // ----------------------------------------------------------------
  // a read clears only the channel it addresses; other channels keep
  // collecting events through the same cycle
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      for (j = 0; j < CHANNELS; j = j + 1) begin
        int_status[j] <= `LSM_INT_RESET;
      end
    end else begin
      for (j = 0; j < CHANNELS; j = j + 1) begin
        // a new event in the clearing cycle survives: set wins over clear
        if (rd_clear && (chan == j)) begin
          int_status[j] <= event_bus[3*j+:3];
        end else begin
          int_status[j] <= int_status[j] | event_bus[3*j+:3];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mask and edge-select registers
  // ----------------------------------------------------------------
  // reset masks every source so no event fires before software sets up
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      for (k = 0; k < CHANNELS; k = k + 1) begin
        mask[k]     <= `LSM_MASK_RESET;
        edge_sel[k] <= `LSM_EDGE_RESET;
      end
    end else begin
      for (k = 0; k < CHANNELS; k = k + 1) begin
        if (wr_mask && (wr_chan == k)) begin
          mask[k] <= hwdata_in[2:0];
        end
        if (wr_edge && (wr_chan == k)) begin
          edge_sel[k] <= hwdata_in[2:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  // a read right behind a write to the same control register sees the
  // new value; without this forwarding it would return the stale one
  reg [31:0] next_rdata;
  reg [2:0]  mask_view;
  reg [2:0]  edge_view;

  always @* begin
    next_rdata = `LSM_WORD_ZERO;
    mask_view  = mask[chan];
    edge_view  = edge_sel[chan];
    if (wr_mask && (wr_idx == idx)) begin
      mask_view = hwdata_in[2:0];
    end
    if (wr_edge && (wr_idx == idx)) begin
      edge_view = hwdata_in[2:0];
    end
    // unmapped and unused offsets fall through and read zero
    if (sel_primary) begin
      next_rdata = lsm_flag_word(line_flags[chan]);
    end else if (sel_secondary) begin
      // bits 7 and 6 stay zero
      next_rdata[`LSM_BIT_LOOPBACK]          = loopback[chan];
      next_rdata[`LSM_ATT_MSB:`LSM_ATT_LSB] = att_code[chan];
    end else if (sel_int) begin
      next_rdata = lsm_flag_word(int_status[chan]);
    end else if (sel_mask) begin
      next_rdata = lsm_flag_word(mask_view);
    end else if (sel_edge) begin
      next_rdata = lsm_flag_word(edge_view);
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // zero wait states: read data is registered at the address phase edge
  // so it stands for the whole data phase; writes to status registers
  // fall through the decode and have no effect
  // hsize is not decoded: every register is one whole word
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      hrdata_out    <= `LSM_WORD_ZERO;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend       <= 1'b0;
      wr_idx        <= 8'h00;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      wr_pend       <= wr_accept & mapped;
      if (accept) begin
        wr_idx <= idx;
      end
      if (rd_accept) begin
        hrdata_out <= next_rdata;
      end
    end
  end

endmodule

`default_nettype wire

// file: verification/lsm_asserts.sv
// concurrent checks on the line status monitor ports
// assumes a bind to lsm_line_status_monitor, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "lsm_regs.vh"
module lsm_asserts #(
  parameter CHANNELS = 4,
  parameter ATT_W    = 6
) (
  input wire logic                      core_clk_in,
  input wire logic                      reset_in,
  input wire logic                      hsel_in,
  input wire logic [31:0]               haddr_in,
  input wire logic [1:0]                htrans_in,
  input wire logic                      hwrite_in,
  input wire logic                      hready_in,
  input wire logic [31:0]               hrdata_out,
  input wire logic                      hreadyout_out,
  input wire logic                      hresp_out,
  input wire logic [CHANNELS-1:0]       driver_short_in,
  input wire logic [CHANNELS-1:0]       alarm_indication_in,
  input wire logic [CHANNELS-1:0]       signal_loss_in,
  input wire logic [CHANNELS-1:0]       remote_loopback_in,
  input wire logic [CHANNELS*ATT_W-1:0] line_attenuation_db_in
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  wire       rd  = hsel_in & htrans_in[1] & hready_in & ~hwrite_in;
  wire [1:0] ch  = haddr_in[9:8];
  wire [5:0] off = haddr_in[7:2];
  wire       ok  = (haddr_in[31:10] == 22'h0) & ~reset_in;
  // inputs held two edges so a flag cannot lag its input at the read
  wire [CHANNELS*(4+ATT_W)-1:0] cur_in = {driver_short_in, alarm_indication_in, signal_loss_in,
                                          remote_loopback_in, line_attenuation_db_in};
  logic [CHANNELS*(4+ATT_W)-1:0] prev_in;
  always @(posedge core_clk_in) begin
    prev_in <= cur_in;
  end
  wire       st  = (prev_in == cur_in);
  function automatic logic [4:0] code(input logic [ATT_W-1:0] db);
    return (db >= `LSM_ATT_TOP_DB) ? `LSM_ATT_OVER_CODE : db[5:1];
  endfunction
  property p_primary;
    rd && ok && off == `LSM_IDX_PRIMARY && !$past(reset_in) && st |=> hrdata_out ==
      {29'h0, $past(driver_short_in[ch]), $past(alarm_indication_in[ch]),
       $past(signal_loss_in[ch])};
  endproperty
  a_primary: assert property (p_primary) else $error("primary flags wrong");
  property p_loop;
    rd && ok && off == `LSM_IDX_SECONDARY && !$past(reset_in) && st |=>
      hrdata_out[5] == $past(remote_loopback_in[ch]);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback flag wrong");
  property p_att;
    rd && ok && off == `LSM_IDX_SECONDARY && !$past(reset_in) && st |=>
      hrdata_out[4:0] == code($past(line_attenuation_db_in[ch*ATT_W +: ATT_W]));
  endproperty
  a_att: assert property (p_att) else $error("attenuation code wrong");
  property p_rsvd;
    rd && ok && off == `LSM_IDX_SECONDARY |=> hrdata_out[31:6] == 26'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_intw;
    rd && ok && off == `LSM_IDX_INT_STATUS |=> hrdata_out[31:3] == 29'h0;
  endproperty
  a_intw: assert property (p_intw) else $error("event word too wide");
  property p_unmap;
    rd && haddr_in[31:10] != 22'h0 |=> hrdata_out == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_okay;
    hreadyout_out && !hresp_out;
  endproperty
  a_okay: assert property (p_okay) else $error("slave stalled or erred");
  property p_hold;
    !rd |=> $stable(hrdata_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_event: cover property (rd && off == `LSM_IDX_INT_STATUS ##1 hrdata_out[2:0] != 3'h0);
  c_over: cover property (rd && off == `LSM_IDX_SECONDARY ##1 hrdata_out[4:0] == 5'h16);
  c_unmap: cover property (rd && haddr_in[31:10] != 22'h0);
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the line status monitor
// assumes lsm_regs.vh on the include path; AHB-Lite master lives here
`timescale 1ns/1ps
`default_nettype none
`include "lsm_regs.vh"
module tb_top;
  typedef struct packed {
    logic [1:0] ch;
    logic [2:0] fl;
    logic       lp;
    logic [5:0] db;
    logic [7:0] pri;
    logic [7:0] sec;
  } lsm_row_t;
  logic        core_clk_in = 1'b0;
  logic        reset_in    = 1'b1;
  logic        hsel_in     = 1'b0;
  logic [31:0] haddr_in    = 32'h0;
  logic [1:0]  htrans_in   = 2'h0;
  logic        hwrite_in   = 1'b0;
  logic [31:0] hwdata_in   = 32'h0;
  logic [3:0]  drv = 4'h0, ais = 4'h0, los = 4'h0, lpb = 4'h0;
  logic [23:0] att = 24'h0;
  logic [31:0] rd;
  wire  [31:0] hrdata_out;
  wire         hreadyout_out, hresp_out;
  int          err_total = 0, n_compared = 0, cyc = 0, i, b, es;
  lsm_row_t    rows [7];
  lsm_line_status_monitor lsm_line_status_monitor_i (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hready_in(hreadyout_out),
    .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .driver_short_in(drv), .alarm_indication_in(ais),
    .signal_loss_in(los), .remote_loopback_in(lpb), .line_attenuation_db_in(att));
  always #2.5 core_clk_in = ~core_clk_in;
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] ad(input logic [1:0] ch, input logic [5:0] idx);
    return {22'h0, ch, idx, 2'h0};
  endfunction
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge core_clk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  // two spare edges let the flag catch up with its input
  task automatic set_line(input int c, input logic [2:0] f, input logic l, input logic [5:0] d);
    @(posedge core_clk_in);
    drv[c] <= f[2];
    ais[c] <= f[1];
    los[c] <= f[0];
    lpb[c] <= l;
    att[c*6 +: 6] <= d;
    repeat (2) @(posedge core_clk_in);
  endtask
  initial begin
    rows[0] = '{2'h0, 3'h0, 1'b0, 6'h00, 8'h00, 8'h00};
    rows[1] = '{2'h1, 3'h4, 1'b1, 6'h01, 8'h04, 8'h20};
    rows[2] = '{2'h2, 3'h2, 1'b0, 6'h02, 8'h02, 8'h01};
    rows[3] = '{2'h3, 3'h1, 1'b1, 6'h2b, 8'h01, 8'h35};
    rows[4] = '{2'h0, 3'h7, 1'b0, 6'h2c, 8'h07, 8'h16};
    rows[5] = '{2'h1, 3'h0, 1'b0, 6'h2d, 8'h00, 8'h16};
    rows[6] = '{2'h2, 3'h5, 1'b1, 6'h3f, 8'h05, 8'h36};
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b0;
    for (i = 0; i < 7; i++) begin
      set_line(rows[i].ch, rows[i].fl, rows[i].lp, rows[i].db);
      bus(1'b0, ad(rows[i].ch, `LSM_IDX_PRIMARY), 32'h0);
      check(rd, {24'h0, rows[i].pri});
      bus(1'b0, ad(rows[i].ch, `LSM_IDX_SECONDARY), 32'h0);
      check(rd, {24'h0, rows[i].sec});
    end
    bus(1'b1, ad(2, `LSM_IDX_PRIMARY), 32'hffff_ffff);
    bus(1'b1, ad(2, `LSM_IDX_SECONDARY), 32'hffff_ffff);
    bus(1'b0, ad(2, `LSM_IDX_PRIMARY), 32'h0);
    check(rd, 32'h5);
    bus(1'b0, ad(2, `LSM_IDX_SECONDARY), 32'h0);
    check(rd, 32'h36);
    bus(1'b0, 32'h0000_0450, 32'h0);
    check(rd, 32'h0);
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    bus(1'b0, ad(3, `LSM_IDX_MASK), 32'h0);
    check(rd, 32'h7);
    bus(1'b0, ad(3, `LSM_IDX_EDGE_SEL), 32'h0);
    check(rd, 32'h0);
    set_line(3, 3'h0, 1'b0, 6'h00);
    bus(1'b1, ad(3, `LSM_IDX_MASK), 32'h0);
    bus(1'b0, ad(3, `LSM_IDX_INT_STATUS), 32'h0);
    check(rd, 32'h0);
    for (es = 0; es < 2; es++) begin
      bus(1'b1, ad(3, `LSM_IDX_EDGE_SEL), {29'h0, {3{es[0]}}});
      for (b = 0; b < 3; b++) begin
        set_line(3, 3'h1 << b, 1'b0, 6'h00);
        bus(1'b0, ad(3, `LSM_IDX_INT_STATUS), 32'h0);
        check(rd, 32'h1 << b);
        bus(1'b0, ad(3, `LSM_IDX_INT_STATUS), 32'h0);
        check(rd, 32'h0);
        set_line(3, 3'h0, 1'b0, 6'h00);
        bus(1'b0, ad(3, `LSM_IDX_INT_STATUS), 32'h0);
        check(rd, es ? 32'h1 << b : 32'h0);
      end
    end
    // an event landing on the clearing read survives it
    fork
      bus(1'b0, ad(3, `LSM_IDX_INT_STATUS), 32'h0);
      begin
        @(posedge core_clk_in);
        los[3] <= 1'b1;
      end
    join
    check(rd, 32'h0);
    bus(1'b0, ad(3, `LSM_IDX_INT_STATUS), 32'h0);
    check(rd, 32'h1);
    bus(1'b1, ad(3, `LSM_IDX_MASK), 32'h7);
    set_line(3, 3'h7, 1'b0, 6'h00);
    bus(1'b0, ad(3, `LSM_IDX_INT_STATUS), 32'h0);
    check(rd, 32'h0);
    finish_test;
  end
endmodule
bind lsm_line_status_monitor lsm_asserts #(.CHANNELS(CHANNELS), .ATT_W(ATT_W)) lsm_asserts_i (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .driver_short_in(driver_short_in), .alarm_indication_in(alarm_indication_in),
  .signal_loss_in(signal_loss_in), .remote_loopback_in(remote_loopback_in),
  .line_attenuation_db_in(line_attenuation_db_in));
`default_nettype wire
